// ### rtl/two_wire_pkg.sv
package two_wire_pkg;

	// register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] OFS_IRQ_DISABLE = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
	localparam logic [7:0] OFS_RX_HOLDING = 8'h30;
	localparam logic [7:0] OFS_TX_HOLDING = 8'h34;

	// status, enable, disable and mask share one layout
	localparam int FLAG_W = 9;
	localparam int BIT_FRAME_COMPLETE = 0;
	localparam int BIT_RX_BYTE_READY = 1;
	localparam int BIT_TX_HOLDING_EMPTY = 2;
	localparam int BIT_RX_OVERRUN = 6;
	localparam int BIT_TX_UNDERRUN = 7;
	localparam int BIT_NACK = 8;

	// control register command bits
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_MASTER_ON = 2;
	localparam int CTRL_MASTER_OFF = 3;

	// mode register field
	localparam int MODE_READ_DIR = 12;

	// reset values
	localparam logic [FLAG_W-1:0] MASK_RESET = 9'h000;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// AHB transfer types
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0] {
		FRAME_IDLE = 2'b00,
		FRAME_MASTER = 2'b01,
		FRAME_SLAVE = 2'b10
	} frame_state_e;

endpackage

// ### rtl/two_wire_status_interrupts.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module two_wire_status_interrupts (
	input wire logic clk_in, // 125 MHz clock
	input wire logic reset_n_in, // synchronous reset, active low
	input wire logic clk_en_in, // freezes all state while low
	input wire logic hsel_in, // AHB slave select
	input wire logic [7:0] haddr_in, // AHB byte address
	input wire logic [1:0] htrans_in, // AHB transfer type
	input wire logic hwrite_in, // AHB write
	input wire logic [2:0] hsize_in, // AHB size, word only
	input wire logic [31:0] hwdata_in, // AHB write data
	input wire logic hready_in, // AHB bus ready
	output logic [31:0] hrdata_out, // AHB read data
	output logic hreadyout_out, // AHB slave ready
	output logic hresp_out, // AHB response, always OKAY
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin
	input wire logic slave_mode_in, // controller runs as slave
	input wire logic shifter_load_req_in, // shifter wants the next byte
	input wire logic shifter_busy_in, // shift register holds data
	input wire logic rx_unload_in, // shifter delivers a received byte
	input wire logic [7:0] rx_byte_in, // received byte from shifter
	input wire logic nack_in, // slave did not acknowledge
	input wire logic stop_sent_in, // STOP has gone out on the bus
	output logic [7:0] tx_byte_out, // byte handed to the shifter
	output logic tx_load_out, // pulse: tx_byte_out taken by shifter
	output logic frame_start_out, // pulse: begin a master frame
	output logic stop_req_out, // pulse: send STOP after current byte
	output logic master_enable_out, // master transfer enabled
	output logic read_dir_out, // master read direction
	output logic irq_out // interrupt, active high level
);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr[7:2] == ofs[7:2]);
	endfunction

	// bus slave
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] rd_word;
	wire addr_phase = hsel_in & hready_in & clk_en_in &
		(htrans_in == two_wire_pkg::HTRANS_NONSEQ || htrans_in == two_wire_pkg::HTRANS_SEQ);
	wire rd_acc = addr_phase & ~hwrite_in;
	wire wr_acc = addr_phase & hwrite_in;
	wire wr_commit = wr_pend & clk_en_in;
	wire wr_ctrl = wr_commit & hit(wr_addr, two_wire_pkg::OFS_CONTROL);
	wire wr_mode = wr_commit & hit(wr_addr, two_wire_pkg::OFS_MODE);
	wire wr_status = wr_commit & hit(wr_addr, two_wire_pkg::OFS_STATUS);
	wire wr_ier = wr_commit & hit(wr_addr, two_wire_pkg::OFS_IRQ_ENABLE);
	wire wr_idr = wr_commit & hit(wr_addr, two_wire_pkg::OFS_IRQ_DISABLE);
	wire wr_thr = wr_commit & hit(wr_addr, two_wire_pkg::OFS_TX_HOLDING);
	wire rd_status = rd_acc & hit(haddr_in, two_wire_pkg::OFS_STATUS);
	wire rd_rhr = rd_acc & hit(haddr_in, two_wire_pkg::OFS_RX_HOLDING);

	// flags and registers
	logic frame_complete;
	logic rx_byte_ready;
	logic tx_holding_empty;
	logic rx_overrun;
	logic tx_underrun;
	logic nack_seen;
	logic [two_wire_pkg::FLAG_W-1:0] irq_mask;
	logic [7:0] rx_holding;
	logic [7:0] tx_holding;
	logic master_on;
	logic read_dir;
	logic stop_asked;
	two_wire_pkg::frame_state_e frame_state;
	two_wire_pkg::frame_state_e next_frame_state;

	wire [two_wire_pkg::FLAG_W-1:0] status_word = {nack_seen, tx_underrun, rx_overrun, 3'h0,
		tx_holding_empty, rx_byte_ready, frame_complete};

	localparam logic [31:0] WORD_ONE = 32'h0000_0001;
	assign rd_word = hit(haddr_in, two_wire_pkg::OFS_STATUS) ? {23'h0, status_word} :
		hit(haddr_in, two_wire_pkg::OFS_IRQ_MASK) ? {23'h0, irq_mask} :
		hit(haddr_in, two_wire_pkg::OFS_RX_HOLDING) ? {24'h000000, rx_holding} :
		hit(haddr_in, two_wire_pkg::OFS_TX_HOLDING) ? {24'h000000, tx_holding} :
		hit(haddr_in, two_wire_pkg::OFS_MODE) ?
			(WORD_ONE << two_wire_pkg::MODE_READ_DIR) & {32{read_dir}} :
		two_wire_pkg::WORD_ZERO;

	// link pins: two flops, then a third stage on SDA for edge finding
	logic scl_s1;
	logic scl_s2;
	logic sda_s1;
	logic sda_s2;
	logic sda_d;
	wire bus_start = scl_s2 & sda_d & ~sda_s2;
	wire bus_stop = scl_s2 & ~sda_d & sda_s2;

	// control decode
	wire master_on_pulse = wr_ctrl & hwdata_in[two_wire_pkg::CTRL_MASTER_ON] &
		~hwdata_in[two_wire_pkg::CTRL_MASTER_OFF];
	wire master_off_pulse = wr_ctrl & hwdata_in[two_wire_pkg::CTRL_MASTER_OFF];
	wire ctrl_start = wr_ctrl & hwdata_in[two_wire_pkg::CTRL_START];
	wire ctrl_stop = wr_ctrl & hwdata_in[two_wire_pkg::CTRL_STOP];
	wire next_master_on = master_off_pulse ? 1'b0 : (master_on_pulse ? 1'b1 : master_on);
	wire master_idle = (frame_state == two_wire_pkg::FRAME_IDLE) & master_on & ~slave_mode_in;
	wire in_master = (frame_state == two_wire_pkg::FRAME_MASTER);

	// a master write frame starts as soon as a byte is written; reads need the start command
	wire start_fire = master_idle & ((wr_thr & ~read_dir) | ctrl_start);

	// shifter hand-over
	wire tx_take = shifter_load_req_in & ~tx_holding_empty;
	wire underrun_ev = shifter_load_req_in & tx_holding_empty;
	wire auto_stop = in_master & ~read_dir & tx_holding_empty & ~shifter_busy_in &
		~stop_asked & ~wr_thr;
	wire stop_fire = (in_master & ~stop_asked & (underrun_ev | ctrl_stop)) | auto_stop;
	wire master_done = in_master & stop_sent_in & tx_holding_empty & ~shifter_busy_in;
	wire slave_begin = slave_mode_in & bus_start;
	wire slave_done = (frame_state == two_wire_pkg::FRAME_SLAVE) & bus_stop;

	always_comb begin
		next_frame_state = frame_state;
		unique case (frame_state)
			two_wire_pkg::FRAME_IDLE: begin
				if (start_fire) begin
					next_frame_state = two_wire_pkg::FRAME_MASTER;
				end else if (slave_begin) begin
					next_frame_state = two_wire_pkg::FRAME_SLAVE;
				end
			end
			two_wire_pkg::FRAME_MASTER: begin
				if (stop_sent_in) begin
					next_frame_state = two_wire_pkg::FRAME_IDLE;
				end
			end
			two_wire_pkg::FRAME_SLAVE: begin
				if (bus_stop) begin
					next_frame_state = two_wire_pkg::FRAME_IDLE;
				end
			end
			default: begin
				next_frame_state = two_wire_pkg::FRAME_IDLE;
			end
		endcase
	end

	// flag equations: in every case a hardware set wins over a clear in the same cycle
	wire fc_set = master_on_pulse | nack_in | master_done | slave_done;
	wire fc_clr = start_fire | slave_begin;
	wire next_frame_complete = fc_set | (frame_complete & ~fc_clr);

	wire rr_set = rx_unload_in;
	wire next_rx_byte_ready = rr_set | (rx_byte_ready & ~rd_rhr);

	wire te_set = tx_take | nack_in | master_on_pulse;
	wire next_tx_holding_empty = te_set | (tx_holding_empty & ~wr_thr);

	// overrun and underrun clear on a status read while frame_complete is up, nack on any status read; all by writing ones
	wire err_rd_clr = rd_status & frame_complete;
	wire ov_set = rx_unload_in & rx_byte_ready;
	wire next_rx_overrun = ov_set | (rx_overrun & ~err_rd_clr &
		~(wr_status & hwdata_in[two_wire_pkg::BIT_RX_OVERRUN]));
	wire next_tx_underrun = underrun_ev | (tx_underrun & ~err_rd_clr &
		~(wr_status & hwdata_in[two_wire_pkg::BIT_TX_UNDERRUN]));
	wire next_nack_seen = nack_in | (nack_seen & ~rd_status &
		~(wr_status & hwdata_in[two_wire_pkg::BIT_NACK]));

	wire [two_wire_pkg::FLAG_W-1:0] next_irq_mask =
		wr_ier ? (irq_mask | hwdata_in[two_wire_pkg::FLAG_W-1:0]) :
		wr_idr ? (irq_mask & ~hwdata_in[two_wire_pkg::FLAG_W-1:0]) :
		irq_mask;

	wire next_stop_asked = in_master & (stop_asked | stop_fire) & ~stop_sent_in;

	// pin synchronisers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else if (clk_en_in) begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// bus slave state: zero wait states, read data captured in the address phase
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			wr_pend <= 1'b0;
		end else if (clk_en_in) begin
			wr_pend <= wr_acc;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			wr_addr <= 8'h00;
		end else if (clk_en_in && wr_acc) begin
			wr_addr <= haddr_in;
		end
	end

	// read clears act at this same edge, so the word returned is the value before the clear
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			hrdata_out <= two_wire_pkg::WORD_ZERO;
		end else if (clk_en_in && rd_acc) begin
			hrdata_out <= rd_word;
		end
	end

	// status flags, one register each; all read zero after reset
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			frame_complete <= 1'b0;
		end else if (clk_en_in) begin
			frame_complete <= next_frame_complete;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rx_byte_ready <= 1'b0;
		end else if (clk_en_in) begin
			rx_byte_ready <= next_rx_byte_ready;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_holding_empty <= 1'b0;
		end else if (clk_en_in) begin
			tx_holding_empty <= next_tx_holding_empty;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rx_overrun <= 1'b0;
		end else if (clk_en_in) begin
			rx_overrun <= next_rx_overrun;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_underrun <= 1'b0;
		end else if (clk_en_in) begin
			tx_underrun <= next_tx_underrun;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			nack_seen <= 1'b0;
		end else if (clk_en_in) begin
			nack_seen <= next_nack_seen;
		end
	end

	// configuration and holding registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_mask <= two_wire_pkg::MASK_RESET;
		end else if (clk_en_in) begin
			irq_mask <= next_irq_mask;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			master_on <= 1'b0;
		end else if (clk_en_in) begin
			master_on <= next_master_on;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			read_dir <= 1'b0;
		end else if (wr_mode) begin
			read_dir <= hwdata_in[two_wire_pkg::MODE_READ_DIR];
		end
	end

	// a byte unloaded while the old one is unread overwrites it; the overrun flag tells software
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			rx_holding <= two_wire_pkg::HOLD_RESET;
		end else if (clk_en_in && rx_unload_in) begin
			rx_holding <= rx_byte_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_holding <= two_wire_pkg::HOLD_RESET;
		end else if (wr_thr) begin
			tx_holding <= hwdata_in[7:0];
		end
	end

	// frame sequencing and strobes to the shifter
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			frame_state <= two_wire_pkg::FRAME_IDLE;
		end else if (clk_en_in) begin
			frame_state <= next_frame_state;
		end
	end

	// remembers a STOP already asked for, so the strobe goes out once per frame
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			stop_asked <= 1'b0;
		end else if (clk_en_in) begin
			stop_asked <= next_stop_asked;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			frame_start_out <= 1'b0;
		end else if (clk_en_in) begin
			frame_start_out <= start_fire;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			stop_req_out <= 1'b0;
		end else if (clk_en_in) begin
			stop_req_out <= stop_fire;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_load_out <= 1'b0;
		end else if (clk_en_in) begin
			tx_load_out <= tx_take;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_byte_out <= two_wire_pkg::HOLD_RESET;
		end else if (clk_en_in && tx_take) begin
			tx_byte_out <= tx_holding;
		end
	end

	// a stalled clock enable also stalls the bus, so no transfer is lost while frozen
	assign hreadyout_out = clk_en_in;
	assign hresp_out = 1'b0;
	assign master_enable_out = master_on;
	assign read_dir_out = read_dir;
	assign irq_out = |(status_word & irq_mask);

endmodule

// ### bench/two_wire_props.sv
`timescale 1ns/1ps
module two_wire_props (
	input wire logic clk_in, // clock
	input wire logic reset_n_in, // sync reset
	input wire logic clk_en_in, // clock enable
	input wire logic hsel_in, // select
	input wire logic [7:0] haddr_in, // address
	input wire logic [1:0] htrans_in, // transfer type
	input wire logic hwrite_in, // write
	input wire logic shifter_load_req_in, // byte wanted
	input wire logic [31:0] hrdata_out, // read data
	input wire logic tx_load_out, // load pulse
	input wire logic frame_start_out, // frame pulse
	input wire logic stop_req_out, // stop pulse
	input wire logic master_enable_out, // master on
	input wire logic irq_out // interrupt
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// read data lands one edge after the address phase
	wire logic rd_req = hsel_in && htrans_in[1] && !hwrite_in && clk_en_in;
	a_load_cause: assert property (tx_load_out |-> $past(shifter_load_req_in)) else $error("load without request");
	a_load_single: assert property (tx_load_out |=> !tx_load_out) else $error("load pulse too long");
	a_start_master: assert property (frame_start_out |-> master_enable_out) else $error("frame while off");
	a_start_single: assert property (frame_start_out |=> !frame_start_out) else $error("frame pulse too long");
	a_stop_single: assert property (stop_req_out |=> !stop_req_out) else $error("stop pulse too long");
	a_rx_upper: assert property (rd_req && haddr_in == two_wire_pkg::OFS_RX_HOLDING |=> hrdata_out[31:8] == 24'h0)
		else $error("rx upper bits set");
	a_mask_upper: assert property (rd_req && haddr_in == two_wire_pkg::OFS_IRQ_MASK |=> hrdata_out[31:9] == 23'h0)
		else $error("mask upper bits set");
	a_status_gap: assert property (rd_req && haddr_in == two_wire_pkg::OFS_STATUS |=> hrdata_out[5:3] == 3'h0)
		else $error("status gap bits set");
	a_reset_quiet: assert property (!$past(reset_n_in) |-> !irq_out && !master_enable_out)
		else $error("active after reset");
endmodule
bind two_wire_status_interrupts two_wire_props i_two_wire_props (.*);

// ### bench/two_wire_far_end.sv
`timescale 1ns/1ps
module two_wire_far_end (
	input wire logic clk_in, // controller clock
	output logic scl_out = 1'b1, // serial clock, pulled up
	output logic sda_out = 1'b1, // serial data, pulled up
	output logic load_req_out = 1'b0, // shifter wants a byte
	output logic unload_out = 1'b0, // received byte valid
	output logic [7:0] byte_out = 8'h00, // received byte
	output logic nack_out = 1'b0, // slave refused a byte
	output logic stop_sent_out = 1'b0 // stop has gone out
);
	// kind 0 load, 1 unload, 2 nack, 3 stop sent; each a one-cycle pulse
	task automatic strobe(input int kind, input logic [7:0] data);
		@(posedge clk_in);
		load_req_out <= (kind == 0);
		unload_out <= (kind == 1);
		nack_out <= (kind == 2);
		stop_sent_out <= (kind == 3);
		byte_out <= data;
		@(posedge clk_in);
		{load_req_out, unload_out, nack_out, stop_sent_out} <= 4'h0;
		byte_out <= ~data; // stale byte must not look valid
	endtask
	// start condition then eight clocks of a 64 ns link clock
	task automatic start_frame;
		#32 sda_out <= 1'b0;
		repeat (8) begin
			#32 scl_out <= 1'b0;
			#32 scl_out <= 1'b1;
		end
	endtask
	task automatic stop_frame;
		#32 sda_out <= 1'b1;
	endtask
endmodule

// ### bench/two_wire_status_interrupts_bench.sv
`timescale 1ns/1ps
module two_wire_status_interrupts_bench;
	localparam logic [7:0] ST = two_wire_pkg::OFS_STATUS;
	localparam logic [7:0] IE = two_wire_pkg::OFS_IRQ_ENABLE;
	localparam logic [7:0] ID = two_wire_pkg::OFS_IRQ_DISABLE;
	localparam logic [7:0] MK = two_wire_pkg::OFS_IRQ_MASK;
	localparam logic [7:0] RX = two_wire_pkg::OFS_RX_HOLDING;
	localparam logic [7:0] TX = two_wire_pkg::OFS_TX_HOLDING;
	localparam logic [7:0] CT = two_wire_pkg::OFS_CONTROL;
	localparam logic [7:0] MD = two_wire_pkg::OFS_MODE;
	logic clk_in = 1'b0, reset_n_in = 1'b0, slave_mode_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
	logic clk_en = 1'b1, busy = 1'b0;
	logic [7:0] haddr_in = 8'h00;
	logic [1:0] htrans_in = 2'h0;
	logic [31:0] hwdata_in = 32'h0, hrdata_out;
	logic [7:0] rx_byte_in, tx_byte_out;
	logic hreadyout_out, hresp_out, scl_in, sda_in, load_req, rx_unload_in, nack_in, stop_sent_in;
	logic tx_load_out, frame_start_out, stop_req_out, master_enable_out, read_dir_out, irq_out;
	int num_errors = 0, check_count = 0, n_start = 0, n_stop = 0;
	logic [31:0] q;
	always #4 clk_in = ~clk_in;
	always @(negedge clk_in) begin
		n_start += frame_start_out;
		n_stop += stop_req_out;
	end
	two_wire_status_interrupts i_two_wire_status_interrupts (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.clk_en_in(clk_en), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .scl_in(scl_in), .sda_in(sda_in),
		.slave_mode_in(slave_mode_in), .shifter_load_req_in(load_req), .shifter_busy_in(busy),
		.rx_unload_in(rx_unload_in), .rx_byte_in(rx_byte_in), .nack_in(nack_in), .stop_sent_in(stop_sent_in),
		.tx_byte_out(tx_byte_out), .tx_load_out(tx_load_out), .frame_start_out(frame_start_out),
		.stop_req_out(stop_req_out), .master_enable_out(master_enable_out), .read_dir_out(read_dir_out),
		.irq_out(irq_out));
	two_wire_far_end i_two_wire_far_end (.clk_in(clk_in), .scl_out(scl_in), .sda_out(sda_in),
		.load_req_out(load_req), .unload_out(rx_unload_in), .byte_out(rx_byte_in), .nack_out(nack_in),
		.stop_sent_out(stop_sent_in));
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready;
		int n;
		@(posedge clk_in);
		for (n = 0; n < 50 && hreadyout_out !== 1'b1; n++) @(posedge clk_in);
		if (n == 50) begin
			num_errors++;
			stop_test();
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= two_wire_pkg::HTRANS_NONSEQ;
		haddr_in <= a;
		hwrite_in <= w;
		wait_ready();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wait_ready();
		q = hrdata_out;
		// let the write land before anyone looks at outputs it drives
		#1;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		cmp(q, exp);
	endtask
	task automatic done(input string name);
		$display("test %s done", name);
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		chk(ST, 32'h0);
		chk(MK, 32'h0);
		chk(RX, 32'h0);
		chk(8'h08, 32'h0);
		done("reset");
		bus(IE, 1'b1, 32'h1C7);
		bus(IE, 1'b1, 32'h0);
		chk(MK, 32'h1C7);
		bus(ID, 1'b1, 32'h6);
		bus(ID, 1'b1, 32'h0);
		bus(MK, 1'b1, 32'h1FF);
		chk(MK, 32'h1C1);
		done("mask");
		bus(8'h00, 1'b1, 32'h4);
		chk(ST, 32'h5);
		cmp({31'h0, master_enable_out}, 32'h1);
		cmp({31'h0, irq_out}, 32'h1);
		bus(ID, 1'b1, 32'h1FF);
		cmp({31'h0, irq_out}, 32'h0);
		done("enable");
		bus(TX, 1'b1, 32'hA5);
		chk(TX, 32'hA5);
		chk(ST, 32'h0);
		@(posedge clk_in);
		busy <= 1'b1;
		i_two_wire_far_end.strobe(0, 8'h00);
		#1 cmp({23'h0, tx_load_out, tx_byte_out}, 32'h1A5);
		chk(ST, 32'h4);
		cmp(n_stop, 32'h0);
		@(posedge clk_in);
		busy <= 1'b0;
		i_two_wire_far_end.strobe(3, 8'h00);
		chk(ST, 32'h5);
		cmp(n_start, 32'h1);
		cmp(n_stop, 32'h1);
		done("transmit");
		i_two_wire_far_end.strobe(0, 8'h00);
		chk(ST, 32'h85);
		chk(ST, 32'h5);
		done("underrun");
		i_two_wire_far_end.strobe(1, 8'h3C);
		chk(ST, 32'h7);
		chk(RX, 32'h3C);
		chk(ST, 32'h5);
		i_two_wire_far_end.strobe(1, 8'h11);
		i_two_wire_far_end.strobe(1, 8'h22);
		chk(ST, 32'h47);
		chk(RX, 32'h22);
		chk(ST, 32'h5);
		done("receive");
		@(posedge clk_in);
		clk_en <= 1'b0;
		i_two_wire_far_end.strobe(1, 8'h77);
		@(posedge clk_in);
		clk_en <= 1'b1;
		chk(ST, 32'h5);
		chk(RX, 32'h22);
		done("freeze");
		bus(IE, 1'b1, 32'h100);
		i_two_wire_far_end.strobe(2, 8'h00);
		#1 cmp({31'h0, irq_out}, 32'h1);
		chk(ST, 32'h105);
		chk(ST, 32'h5);
		cmp({31'h0, irq_out}, 32'h0);
		done("nack");
		bus(MD, 1'b1, 32'h1000);
		chk(MD, 32'h1000);
		cmp({31'h0, read_dir_out}, 32'h1);
		bus(CT, 1'b1, 32'h1);
		chk(ST, 32'h4);
		cmp(n_start, 32'h2);
		i_two_wire_far_end.strobe(3, 8'h00);
		chk(ST, 32'h5);
		cmp(n_stop, 32'h1);
		bus(MD, 1'b1, 32'h0);
		done("read");
		@(posedge clk_in);
		slave_mode_in <= 1'b1;
		i_two_wire_far_end.start_frame();
		repeat (8) @(posedge clk_in);
		chk(ST, 32'h4);
		i_two_wire_far_end.stop_frame();
		repeat (8) @(posedge clk_in);
		chk(ST, 32'h5);
		done("slave");
		stop_test();
	end
endmodule
